// ### design/vrdc_control.sv
// Reference decode, droop trims and channel-current balance for a multiphase regulator.
// Assumes SERIAL_VOLTAGE_ID_BUS frames and PMBus commands arrive already decoded, on clk_sys;
// sensed currents come from converters on clk_sys; the mode strap is an asynchronous pin.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Mean current is active sum over active count
// - Per-channel duty trim from deviation against mean
// - Balance weights in registers F7 through FC
// - Averaged droop current routed to feedback node
// - Writable bit disconnects droop from feedback
// - Reference set from serial voltage bus code
// - Zero code off; 250mV+5mV steps, coarse doubles
// - Fine mode offset 5 mV steps, -640..635
// - Coarse mode offset 10 mV steps, -1280..1270
// - Mode strap pin selects fine or coarse
// - Bits 9:5 set feedback trim current
// - Trim current sign gives offset sign
// - Bits 4:0 inject via monitor, inverted polarity
module vrdc_control (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic modeStrapPin,
  input wire logic svidSetValid,
  input wire logic [7:0] svidSetCode,
  input wire logic svidOffsetValid,
  input wire logic [7:0] svidOffsetCode,
  input wire logic [vrdc_pkg::NUM_CH-1:0] channelActive,
  input wire logic [vrdc_pkg::NUM_CH*vrdc_pkg::CUR_W-1:0] channelCurrent,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [15:0] regRdData,
  output logic regRdValid,
  output logic coarseMode,
  output logic outputOff,
  output logic [11:0] referenceMv,
  output logic signed [11:0] offsetMv,
  output logic droopToFeedback,
  output logic signed [4:0] feedbackTrimQuarterUa,
  output logic signed [5:0] monitorTrimQuarterUa,
  output logic [vrdc_pkg::CUR_W-1:0] meanChannelCurrent,
  output logic [vrdc_pkg::NUM_CH*vrdc_pkg::TRIM_W-1:0] dutyTrim
);
  logic strapMeta_reg;
  logic strapSync_reg;
  logic [15:0] voutCeiling_reg;
  logic [15:0] bootVoltage_reg;
  logic [vrdc_pkg::TRIM_STORE_W-1:0] droopTrim_reg;
  logic droopDisconnect_reg;
  logic [7:0] weight_reg [vrdc_pkg::NUM_CH];
  logic [7:0] setCode_reg;
  logic [7:0] offsetCode_reg;
  vrdc_pkg::vrdc_bal_state_t balState_reg;
  vrdc_pkg::vrdc_bal_state_t balState_next;
  logic divStart;
  logic divBusy;
  logic divDone;
  logic [vrdc_pkg::SUM_W-1:0] divQuotient;
  logic [vrdc_pkg::SUM_W-1:0] activeSum;
  logic [vrdc_pkg::CNT_W-1:0] activeCount;
  logic [vrdc_pkg::CUR_W-1:0] sampleCur [vrdc_pkg::NUM_CH];
  logic [vrdc_pkg::NUM_CH-1:0] sampleActive_reg;

  function automatic logic [11:0] decodeReference(input logic [7:0] code, input logic coarse);
    logic [11:0] fine;
    fine = vrdc_pkg::FINE_BASE_MV + 12'(code - 8'h01) * vrdc_pkg::FINE_STEP_MV;
    if (code == vrdc_pkg::CODE_OUTPUT_OFF) begin
      decodeReference = 12'h000;
    end else if (coarse) begin
      decodeReference = {fine[10:0], 1'b0};
    end else begin
      decodeReference = fine;
    end
  endfunction : decodeReference

  function automatic logic signed [11:0] decodeOffset(input logic [7:0] code, input logic coarse);
    logic signed [11:0] fine;
    fine = 12'($signed(code)) * $signed(vrdc_pkg::OFFSET_STEP_MV);
    decodeOffset = coarse ? (fine <<< 1) : fine;
  endfunction : decodeOffset

  function automatic logic isWeightAddr(input logic [7:0] addr);
    isWeightAddr = (addr >= vrdc_pkg::ADDR_WEIGHT_FIRST) && (addr <= vrdc_pkg::ADDR_WEIGHT_LAST);
  endfunction : isWeightAddr

  // Mode strap synchroniser; the pin is static in practice
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      strapMeta_reg <= 1'b0;
      strapSync_reg <= 1'b0;
    end else begin
      strapMeta_reg <= modeStrapPin;
      strapSync_reg <= strapMeta_reg;
    end
  end

  // Register writes
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      voutCeiling_reg <= vrdc_pkg::RST_VOUT_CEILING;
      bootVoltage_reg <= vrdc_pkg::RST_BOOT_VOLTAGE;
      droopTrim_reg <= vrdc_pkg::RST_DROOP_TRIM;
      droopDisconnect_reg <= 1'b0;
      for (int i = 0; i < vrdc_pkg::NUM_CH; i++) begin
        weight_reg[i] <= vrdc_pkg::RST_WEIGHT;
      end
    end else if (regWrEn) begin
      // Ceiling and boot are only stored; keeping them consistent with the mode is the host's job
      if (regAddr == vrdc_pkg::ADDR_VOUT_CEILING) begin
        voutCeiling_reg <= regWrData;
      end
      if (regAddr == vrdc_pkg::ADDR_BOOT_VOLTAGE) begin
        bootVoltage_reg <= regWrData;
      end
      if (regAddr == vrdc_pkg::ADDR_DROOP_TRIM) begin
        droopTrim_reg <= regWrData[vrdc_pkg::TRIM_STORE_W-1:0];
      end
      if (regAddr == vrdc_pkg::ADDR_DROOP_CTRL) begin
        droopDisconnect_reg <= regWrData[vrdc_pkg::CTRL_DISCONNECT_BIT];
      end
      if (isWeightAddr(regAddr)) begin
        weight_reg[3'(regAddr - vrdc_pkg::ADDR_WEIGHT_FIRST)] <= regWrData[7:0];
      end
    end
  end

  // Register reads, answered one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      regRdData <= 16'h0000;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        if (regAddr == vrdc_pkg::ADDR_VOUT_CEILING) begin
          regRdData <= voutCeiling_reg;
        end else if (regAddr == vrdc_pkg::ADDR_BOOT_VOLTAGE) begin
          regRdData <= bootVoltage_reg;
        end else if (regAddr == vrdc_pkg::ADDR_DROOP_TRIM) begin
          regRdData <= 16'(droopTrim_reg);
        end else if (regAddr == vrdc_pkg::ADDR_DROOP_CTRL) begin
          regRdData <= 16'(droopDisconnect_reg);
        end else if (regAddr == vrdc_pkg::ADDR_STATUS) begin
          regRdData <= {8'h00, sampleActive_reg[5:0], outputOff, coarseMode};
        end else if (isWeightAddr(regAddr)) begin
          regRdData <= {8'h00, weight_reg[3'(regAddr - vrdc_pkg::ADDR_WEIGHT_FIRST)]};
        end else begin
          regRdData <= 16'h0000;
        end
      end
    end
  end

  // Voltage identification codes from the serial bus
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      setCode_reg <= vrdc_pkg::CODE_OUTPUT_OFF;
      offsetCode_reg <= 8'h00;
    end else begin
      if (svidSetValid) begin
        setCode_reg <= svidSetCode;
      end
      if (svidOffsetValid) begin
        offsetCode_reg <= svidOffsetCode;
      end
    end
  end

  // Reference outputs follow the stored codes and the synchronised strap
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      coarseMode <= 1'b0;
      outputOff <= 1'b1;
      referenceMv <= 12'h000;
      offsetMv <= 12'sh000;
    end else begin
      coarseMode <= strapSync_reg;
      outputOff <= (setCode_reg == vrdc_pkg::CODE_OUTPUT_OFF);
      referenceMv <= decodeReference(setCode_reg, strapSync_reg);
      offsetMv <= decodeOffset(offsetCode_reg, strapSync_reg);
    end
  end

  // Droop routing and trim currents, in quarter microamp units
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      droopToFeedback <= 1'b1;
      feedbackTrimQuarterUa <= 5'sh00;
      monitorTrimQuarterUa <= 6'sh00;
    end else begin
      droopToFeedback <= !droopDisconnect_reg;
      // Sign carried straight through, so offset sign follows current sign
      feedbackTrimQuarterUa <= $signed(droopTrim_reg[vrdc_pkg::TRIM_FB_MSB:vrdc_pkg::TRIM_FB_LSB]);
      // Extra bit because negating the most negative code overflows five bits
      monitorTrimQuarterUa <= -6'($signed(droopTrim_reg[vrdc_pkg::TRIM_MON_MSB:vrdc_pkg::TRIM_MON_LSB]));
    end
  end

  // Sum and count of active channels
  always_comb begin
    activeSum = '0;
    activeCount = '0;
    for (int i = 0; i < vrdc_pkg::NUM_CH; i++) begin
      sampleCur[i] = channelCurrent[i*vrdc_pkg::CUR_W +: vrdc_pkg::CUR_W];
      if (channelActive[i]) begin
        activeSum = activeSum + vrdc_pkg::SUM_W'(sampleCur[i]);
        activeCount = activeCount + 3'h1;
      end
    end
  end

  always_comb begin
    balState_next = balState_reg;
    divStart = 1'b0;
    case (balState_reg)
      vrdc_pkg::VRDC_BAL_IDLE: begin
        divStart = !divBusy;
        balState_next = divBusy ? vrdc_pkg::VRDC_BAL_IDLE : vrdc_pkg::VRDC_BAL_WAIT;
      end
      vrdc_pkg::VRDC_BAL_WAIT: begin
        if (divDone) begin
          balState_next = vrdc_pkg::VRDC_BAL_LOAD;
        end
      end
      vrdc_pkg::VRDC_BAL_LOAD: begin
        balState_next = vrdc_pkg::VRDC_BAL_IDLE;
      end
      default: begin
        balState_next = vrdc_pkg::VRDC_BAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      balState_reg <= vrdc_pkg::VRDC_BAL_IDLE;
      sampleActive_reg <= '0;
    end else begin
      balState_reg <= balState_next;
      if (divStart) begin
        sampleActive_reg <= channelActive;
      end
    end
  end

  vrdc_mean_divider u_divider (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .start(divStart),
    .dividend(activeSum),
    .divisor(activeCount),
    .busy(divBusy),
    .done(divDone),
    .quotient(divQuotient)
  );

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      meanChannelCurrent <= '0;
    end else if (divDone) begin
      meanChannelCurrent <= divQuotient[vrdc_pkg::CUR_W-1:0];
    end
  end

  // Positive trim means the channel runs below the mean; the 22-bit product cannot overflow
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dutyTrim <= '0;
    end else if (balState_reg == vrdc_pkg::VRDC_BAL_LOAD) begin
      for (int i = 0; i < vrdc_pkg::NUM_CH; i++) begin
        if (sampleActive_reg[i]) begin
          dutyTrim[i*vrdc_pkg::TRIM_W +: vrdc_pkg::TRIM_W] <= vrdc_pkg::TRIM_W'(
            (($signed({10'h000, meanChannelCurrent}) - $signed({10'h000, sampleCur[i]}))
              * $signed({14'h0000, weight_reg[i]})) >>> vrdc_pkg::WEIGHT_SHIFT);
        end else begin
          dutyTrim[i*vrdc_pkg::TRIM_W +: vrdc_pkg::TRIM_W] <= '0;
        end
      end
    end
  end
endmodule : vrdc_control
`default_nettype wire

// ### design/vrdc_mean_divider.sv
// Iterative restoring divider for the mean channel current.
// Assumes start is a one-cycle pulse issued only while busy is low.
`timescale 1ns/1ps
`default_nettype none
module vrdc_mean_divider (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic start,
  input wire logic [vrdc_pkg::SUM_W-1:0] dividend,
  input wire logic [vrdc_pkg::CNT_W-1:0] divisor,
  output logic busy,
  output logic done,
  output logic [vrdc_pkg::SUM_W-1:0] quotient
);
  logic [vrdc_pkg::SUM_W-1:0] dividend_reg;
  logic [vrdc_pkg::CNT_W:0] remain_reg;
  logic [vrdc_pkg::CNT_W-1:0] divisor_reg;
  logic [3:0] step_reg;
  logic [vrdc_pkg::CNT_W:0] trial;

  always_comb begin
    trial = {remain_reg[vrdc_pkg::CNT_W-1:0], dividend_reg[vrdc_pkg::SUM_W-1]};
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      quotient <= '0;
      dividend_reg <= '0;
      remain_reg <= '0;
      divisor_reg <= '0;
      step_reg <= 4'h0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        dividend_reg <= dividend;
        divisor_reg <= divisor;
        remain_reg <= '0;
        step_reg <= 4'(vrdc_pkg::SUM_W);
      end else if (busy) begin
        // Remainder stays below divisor, so one extra bit holds the trial
        if (trial >= {1'b0, divisor_reg}) begin
          remain_reg <= trial - {1'b0, divisor_reg};
          dividend_reg <= {dividend_reg[vrdc_pkg::SUM_W-2:0], 1'b1};
        end else begin
          remain_reg <= trial;
          dividend_reg <= {dividend_reg[vrdc_pkg::SUM_W-2:0], 1'b0};
        end
        step_reg <= step_reg - 4'h1;
        if (step_reg == 4'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
          // No active channel gives a zero mean rather than an overflow
          if (divisor_reg == '0) begin
            quotient <= '0;
          end else if (trial >= {1'b0, divisor_reg}) begin
            quotient <= {dividend_reg[vrdc_pkg::SUM_W-2:0], 1'b1};
          end else begin
            quotient <= {dividend_reg[vrdc_pkg::SUM_W-2:0], 1'b0};
          end
        end
      end
    end
  end
endmodule : vrdc_mean_divider
`default_nettype wire

// ### design/vrdc_pkg.sv
// Constants for the output reference and droop control block.
// Assumes a single 20 MHz system clock; all register access comes from the PMBus command decoder.
package vrdc_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int NUM_CH = 6;
  localparam int CUR_W = 12;
  localparam int SUM_W = 15;
  localparam int CNT_W = 3;
  localparam int TRIM_W = 17;
  localparam int WEIGHT_SHIFT = 4;

  // Register offsets (PMBus command codes)
  localparam logic [7:0] ADDR_VOUT_CEILING = 8'h24;
  localparam logic [7:0] ADDR_DROOP_TRIM = 8'hE4;
  localparam logic [7:0] ADDR_BOOT_VOLTAGE = 8'hE6;
  localparam logic [7:0] ADDR_DROOP_CTRL = 8'hE8;
  localparam logic [7:0] ADDR_STATUS = 8'hE9;
  localparam logic [7:0] ADDR_WEIGHT_FIRST = 8'hF7;
  localparam logic [7:0] ADDR_WEIGHT_LAST = 8'hFC;

  // Fields of the droop offset trim and droop control registers
  localparam int TRIM_FB_MSB = 9;
  localparam int TRIM_FB_LSB = 5;
  localparam int TRIM_MON_MSB = 4;
  localparam int TRIM_MON_LSB = 0;
  localparam int TRIM_STORE_W = 10;
  localparam int CTRL_DISCONNECT_BIT = 0;

  // Reset values
  localparam logic [15:0] RST_VOUT_CEILING = 16'h0000;
  localparam logic [15:0] RST_BOOT_VOLTAGE = 16'h0000;
  localparam logic [TRIM_STORE_W-1:0] RST_DROOP_TRIM = 10'h000;
  localparam logic [7:0] RST_WEIGHT = 8'h10;

  // Reference decode, millivolts
  localparam logic [11:0] FINE_BASE_MV = 12'h0FA;
  localparam logic [11:0] FINE_STEP_MV = 12'h005;
  localparam logic [11:0] OFFSET_STEP_MV = 12'h005;
  localparam logic [7:0] CODE_OUTPUT_OFF = 8'h00;

  typedef enum logic [1:0] {
    VRDC_BAL_IDLE = 2'b00,
    VRDC_BAL_WAIT = 2'b01,
    VRDC_BAL_LOAD = 2'b10
  } vrdc_bal_state_t;
endpackage : vrdc_pkg

// ### tb/vrdc_asserts.sv
// Port-level checks on the reference and droop control block.
// Bound to every vrdc_control; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module vrdc_asserts (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic modeStrapPin,
  input wire logic svidSetValid,
  input wire logic [7:0] svidSetCode,
  input wire logic svidOffsetValid,
  input wire logic [7:0] svidOffsetCode,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic regRdValid,
  input wire logic coarseMode,
  input wire logic outputOff,
  input wire logic [11:0] referenceMv,
  input wire logic signed [11:0] offsetMv,
  input wire logic droopToFeedback,
  input wire logic signed [4:0] feedbackTrimQuarterUa,
  input wire logic signed [5:0] monitorTrimQuarterUa
);
  logic [15:0] wdD1;
  logic [15:0] wdD2;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  always_ff @(posedge clk_sys) begin
    wdD1 <= regWrData;
    wdD2 <= wdD1;
  end
  function automatic logic [11:0] refMv(input logic [7:0] c, input logic k);
    if (c == 8'h00)
      return 12'h000;
    return (12'h0FA + 12'h005 * {4'h0, c - 8'h01}) << k;
  endfunction : refMv
  a_read_pulse: assert property (regRdEn |=> regRdValid)
    else $error("read valid missing");
  a_valid_cause: assert property (regRdValid |-> $past(regRdEn))
    else $error("read valid without request");
  a_ref_decode: assert property (svidSetValid |-> ##2 referenceMv == refMv($past(svidSetCode, 2), coarseMode))
    else $error("reference decode wrong");
  a_off_flag: assert property (svidSetValid |-> ##2 outputOff == ($past(svidSetCode, 2) == 8'h00))
    else $error("output off flag wrong");
  a_offset_decode: assert property (svidOffsetValid |-> ##2 offsetMv ==
    $signed($past(svidOffsetCode, 2)) * (coarseMode ? 10 : 5))
    else $error("offset decode wrong");
  a_coarse_track: assert property (modeStrapPin [*4] |=> coarseMode)
    else $error("coarse mode not followed");
  a_fine_track: assert property (!modeStrapPin [*4] |=> !coarseMode)
    else $error("fine mode not followed");
  a_trim_fields: assert property (regWrEn && regAddr == 8'hE4 |-> ##2
    feedbackTrimQuarterUa == wdD2[9:5] && monitorTrimQuarterUa == -$signed({wdD2[4], wdD2[4:0]}))
    else $error("trim fields wrong");
  a_droop_switch: assert property (regWrEn && regAddr == 8'hE8 |-> ##2 droopToFeedback == !wdD2[0])
    else $error("droop switch wrong");
  a_reset_state: assert property (disable iff (1'b0) !resetn |=> droopToFeedback && outputOff)
    else $error("reset state wrong");
  cover property (svidSetValid && svidSetCode == 8'h00);
  cover property (svidOffsetValid && svidOffsetCode[7]);
  cover property (regRdEn && regAddr == 8'hE4);
endmodule : vrdc_asserts
bind vrdc_control vrdc_asserts u_chk (.clk_sys, .resetn, .modeStrapPin, .svidSetValid, .svidSetCode,
  .svidOffsetValid, .svidOffsetCode, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdValid,
  .coarseMode, .outputOff, .referenceMv, .offsetMv, .droopToFeedback, .feedbackTrimQuarterUa,
  .monitorTrimQuarterUa);
`default_nettype wire

// ### tb/vrdc_control_test.sv
// Self-checking bench for the reference and droop control block.
// Host model drives the voltage bus; bench drives registers and currents.
`timescale 1ns/1ps
`default_nettype none
module vrdc_control_test;
  logic clk_sys, resetn, modeStrapPin, regWrEn, regRdEn, regRdValid;
  logic coarseMode, outputOff, droopToFeedback, svidSetValid, svidOffsetValid;
  logic [7:0] svidSetCode, svidOffsetCode, regAddr;
  logic [5:0] channelActive;
  logic [vrdc_pkg::NUM_CH*vrdc_pkg::CUR_W-1:0] channelCurrent;
  logic [15:0] regWrData, regRdData;
  logic [11:0] referenceMv, meanChannelCurrent;
  logic signed [11:0] offsetMv;
  logic signed [4:0] feedbackTrimQuarterUa;
  logic signed [5:0] monitorTrimQuarterUa;
  logic [vrdc_pkg::NUM_CH*vrdc_pkg::TRIM_W-1:0] dutyTrim;
  int failCount, checks, cycles;
  vrdc_serial_voltage_id_bus_host u_host (.clk_sys, .svidSetValid, .svidSetCode, .svidOffsetValid, .svidOffsetCode);
  vrdc_control u_dut (.clk_sys, .resetn, .modeStrapPin, .svidSetValid, .svidSetCode, .svidOffsetValid,
    .svidOffsetCode, .channelActive, .channelCurrent, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData, .regRdValid, .coarseMode, .outputOff, .referenceMv, .offsetMv, .droopToFeedback,
    .feedbackTrimQuarterUa, .monitorTrimQuarterUa, .meanChannelCurrent, .dutyTrim);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  // Ceiling sized for about ten times the expected run
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failCount++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1;
    chk("regRdValid", 1, regRdValid);
    chk("regRdData", e, regRdData);
  endtask : rd
  task automatic t_regs();
    chk("droopToFeedback", 1, droopToFeedback);
    chk("outputOff", 1, outputOff);
    wr(8'h24, 16'h0640);
    wr(8'hE6, 16'h0320);
    rd(8'h24, 16'h0640);
    rd(8'hE6, 16'h0320);
    wr(8'hE4, 16'hFFFF);
    rd(8'hE4, 16'h03FF);
    rd(8'h30, 16'h0000);
    for (int a = 8'hF7; a <= 8'hFC; a++) rd(a[7:0], 16'h0010);
    wr(8'hF7, 16'h1220);
    rd(8'hF7, 16'h0020);
  endtask : t_regs
  task automatic t_decode();
    logic [7:0] codes[5] = '{8'h00, 8'h01, 8'h02, 8'h7F, 8'hFF};
    int e;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys);
      modeStrapPin <= m[0];
      repeat (6) @(posedge clk_sys);
      #1;
      chk("coarseMode", m, coarseMode);
      for (int i = 0; i < 5; i++) begin
        u_host.send_set(codes[i], i);
        settle();
        e = (codes[i] == 8'h00) ? 0 : (250 + 5 * (codes[i] - 1)) << m;
        chk("referenceMv", e, referenceMv);
        chk("outputOff", codes[i] == 8'h00, outputOff);
        u_host.send_offset(codes[i] ^ 8'h80, 0);
        settle();
        e = $signed(codes[i] ^ 8'h80) * (m ? 10 : 5);
        chk("offsetMv", e, offsetMv);
      end
    end
  endtask : t_decode
  task automatic t_trim();
    logic [15:0] pats[3] = '{16'h0201, 16'h01F0, 16'h0000};
    for (int i = 0; i < 3; i++) begin
      wr(8'hE4, pats[i]);
      settle();
      chk("feedbackTrim", $signed(pats[i][9:5]), feedbackTrimQuarterUa);
      chk("monitorTrim", -$signed({pats[i][4], pats[i][4:0]}), monitorTrimQuarterUa);
    end
  endtask : t_trim
  task automatic t_droop();
    wr(8'hE8, 16'h0001);
    settle();
    chk("droopToFeedback", 0, droopToFeedback);
    rd(8'hE8, 16'h0001);
    wr(8'hE8, 16'h0000);
    settle();
    chk("droopToFeedback", 1, droopToFeedback);
  endtask : t_droop
  task automatic t_balance();
    int exp[6] = '{200, 0, -100, 0, 0, 0};
    @(posedge clk_sys);
    channelActive <= 6'b000111;
    channelCurrent <= {24'h000000, 12'hFA0, 12'h12C, 12'h0C8, 12'h064};
    repeat (60) @(posedge clk_sys);
    #1;
    chk("meanChannelCurrent", 200, meanChannelCurrent);
    for (int i = 0; i < 6; i++) chk("dutyTrim", exp[i], $signed(dutyTrim[17*i +: 17]));
    rd(8'hE9, 16'h001D);
    @(posedge clk_sys);
    channelActive <= 6'b000000;
    repeat (60) @(posedge clk_sys);
    #1;
    chk("meanChannelCurrent", 0, meanChannelCurrent);
    chk("dutyTrim", 0, dutyTrim[16:0]);
  endtask : t_balance
  initial begin
    resetn = 1'b0;
    modeStrapPin = 1'b0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 16'h0000;
    channelActive = 6'h00;
    channelCurrent = '0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    #1;
    t_regs();
    t_trim();
    t_droop();
    t_decode();
    t_balance();
    final_report();
  end
endmodule : vrdc_control_test
`default_nettype wire

// ### tb/vrdc_serial_voltage_id_bus_host.sv
// Host side of the serial voltage bus: issues set and offset codes.
// Drives just after rising edges of clk_sys; the gap argument makes it slow.
`timescale 1ns/1ps
`default_nettype none
module vrdc_serial_voltage_id_bus_host (
  input wire logic clk_sys,
  output logic svidSetValid,
  output logic [7:0] svidSetCode,
  output logic svidOffsetValid,
  output logic [7:0] svidOffsetCode
);
  initial begin
    svidSetValid = 1'b0;
    svidSetCode = 8'hA5;
    svidOffsetValid = 1'b0;
    svidOffsetCode = 8'h5A;
  end
  // Idle code lanes carry the inverse, so a stale code cannot pass for a held one
  task automatic send_set(input logic [7:0] code, input int gap);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    svidSetValid <= 1'b1;
    svidSetCode <= code;
    @(posedge clk_sys);
    svidSetValid <= 1'b0;
    svidSetCode <= ~code;
  endtask : send_set
  task automatic send_offset(input logic [7:0] code, input int gap);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    svidOffsetValid <= 1'b1;
    svidOffsetCode <= code;
    @(posedge clk_sys);
    svidOffsetValid <= 1'b0;
    svidOffsetCode <= ~code;
  endtask : send_offset
endmodule : vrdc_serial_voltage_id_bus_host
`default_nettype wire
